// File: hw/ohs_map.vh
// Constants for the overload hiccup sequencer: timing counts and feedback codes.
// Assumes a 200 MHz clock and an 8-bit feedback code in 20 mV steps (0..5.1 V).
// Functional notes
// - Overload past timer stops drive, starts recovery
// - Fault acknowledged only after 64 ms continuous
// - Stopped: charge below low, else wait fall
// - Ignore start level while recovery timer runs
// - Every restart begins with soft-start
// - Brown-out recovery aborts hiccup, restart next
// - Latch option: overload stops pulses, supply hiccups
// - Start-up: undervoltage with error flag latches; code latches only with LATCH_OPT, else hiccups
// - Latch clears only on brown-out or reset level
// - Undervoltage without error flag: auto-recovery restart
// - Pre-short latch armed only during start-up
// - Fixed option picks auto-recovery or latch
// - Foldback below 1.9 V, 26 kHz at 1.5 V
// - Peak setpoint tracks 3.2..1 V, frozen below
// - Skip cycle below 0.8 V feedback
// - Restart at start level only if line good
`ifndef OHS_MAP_VH
`define OHS_MAP_VH
`define OHS_CLK_MHZ        200
`define OHS_TICK_US        1
`define OHS_TICK_CYC       (`OHS_CLK_MHZ * `OHS_TICK_US)
`define OHS_FAULT_MS       64
`define OHS_FAULT_TICKS    (`OHS_FAULT_MS * 1000 / `OHS_TICK_US)
`define OHS_RECOV_S        1
`define OHS_RECOV_TICKS    (`OHS_RECOV_S * 1000000 / `OHS_TICK_US)
`define OHS_FB_FOLD        8'h5F
`define OHS_FB_FMIN        8'h4B
`define OHS_FB_PEAK_HI     8'hA0
`define OHS_FB_PEAK_LO     8'h32
`define OHS_FB_SKIP        8'h28
`define OHS_PEAK_FROZEN    8'h0D
`define OHS_FREQ_NOM_KHZ   8'h41
`define OHS_FREQ_MIN_KHZ   8'h1A
`define OHS_ST_START       3'h0
`define OHS_ST_RUN         3'h1
`define OHS_ST_HICCUP      3'h2
`define OHS_ST_LATCH       3'h3
`endif

// File: hw/ohs_sequencer.v
// Overload hiccup sequencer: drive gating, start-up source control, feedback mapping.
// Assumes comparator flags arrive as levels on the clock domain edge, analog front end outside.
`timescale 1ns/10ps
`include "ohs_map.vh"
module ohs_sequencer #(
  parameter [31:0] TICK_CYC    = `OHS_TICK_CYC,
  parameter [31:0] FAULT_TICKS = `OHS_FAULT_TICKS,
  parameter [31:0] RECOV_TICKS = `OHS_RECOV_TICKS,
  parameter        LATCH_OPT   = 1'b0
) (
  input  wire       clock,
  input  wire       resetn,
  input  wire       error_flag,
  input  wire       vcc_above_on,
  input  wire       vcc_below_min,
  input  wire       vcc_below_reset,
  input  wire       line_loss_detect,
  input  wire [7:0] feedback_level,
  output reg        gate_drive_enable,
  output reg        startup_source_input,
  output reg        soft_start,
  output reg        latched_off,
  output reg        skip_cycle,
  output reg  [7:0] switch_freq_khz,
  output reg  [7:0] peak_setpoint
);
  localparam [2:0] ST_START  = `OHS_ST_START;
  localparam [2:0] ST_RUN    = `OHS_ST_RUN;
  localparam [2:0] ST_HICCUP = `OHS_ST_HICCUP;
  localparam [2:0] ST_LATCH  = `OHS_ST_LATCH;

  // Two-stage synchronisers, first stage read only by the second
  wire [4:0] raw;
  wire [4:0] sync_w;

  assign raw = {error_flag, vcc_above_on, vcc_below_min, vcc_below_reset, line_loss_detect};

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      reg s1_r;
      reg s2_r;

      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= raw[g];
          s2_r <= s1_r;
        end
      end

      assign sync_w[g] = s2_r;
    end
  endgenerate

  wire err   = sync_w[4];
  wire v_on  = sync_w[3];
  wire v_min = sync_w[2];
  wire v_rst = sync_w[1];
  wire loss  = sync_w[0];

  // Line-good edge marks brown-out recovery
  reg  loss_d_r;
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      loss_d_r <= 1'b0;
    else
      loss_d_r <= loss;
  end
  wire bo_recover = loss_d_r & ~loss;

  // Tick from fixed reference period
  reg  [31:0] pre_r;
  wire        tick = (pre_r == TICK_CYC - 32'h0000_0001);
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      pre_r <= 32'h0000_0000;
    else
      pre_r <= tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
  end

  reg  [2:0]  st_r;
  reg  [2:0]  st_nxt;
  reg  [31:0] flt_r;
  reg  [31:0] rec_r;
  reg         charge_r;
  reg         charge_nxt;
  reg         v_on_d_r;
  wire        on_rise  = v_on & ~v_on_d_r;
  wire        uvlo     = v_min;
  wire        flt_done = err & (flt_r >= FAULT_TICKS);
  wire        rec_busy = (rec_r != 32'h0000_0000);

  // Fault timer restarts on any gap: short overloads never trip
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      flt_r <= 32'h0000_0000;
    else if (st_r != ST_RUN || !err)
      flt_r <= 32'h0000_0000;
    else if (tick && !flt_done)
      flt_r <= flt_r + 32'h0000_0001;
  end

  // Recovery timer loads on RUN-to-HICCUP entry, cleared by brown-out recovery
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      rec_r <= 32'h0000_0000;
    else if (bo_recover)
      rec_r <= 32'h0000_0000;
    else if (st_r == ST_RUN && st_nxt == ST_HICCUP)
      rec_r <= RECOV_TICKS;
    else if (tick && rec_busy)
      rec_r <= rec_r - 32'h0000_0001;
  end

  always @* begin
    st_nxt     = st_r;
    charge_nxt = charge_r;
    // Charge from low level up to start level, in every off state
    if (v_min)
      charge_nxt = 1'b1;
    else if (v_on)
      charge_nxt = 1'b0;
    case (st_r)
      ST_START: begin
        // Pre-short only armed here
        if (uvlo && err && LATCH_OPT)
          st_nxt = ST_LATCH;
        else if (uvlo)
          st_nxt = ST_HICCUP;
        else if (flt_done)
          st_nxt = LATCH_OPT ? ST_LATCH : ST_HICCUP;
        else if (!err)
          st_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (flt_done)
          st_nxt = LATCH_OPT ? ST_LATCH : ST_HICCUP;
        else if (uvlo)
          st_nxt = ST_HICCUP;
      end
      ST_HICCUP: begin
        // Hiccup waits out the recovery timer; only a start-level rise with line good restarts
        if (on_rise && !rec_busy && !loss)
          st_nxt = ST_START;
      end
      ST_LATCH: begin
        if (bo_recover || v_rst)
          st_nxt = ST_HICCUP;
      end
      default: st_nxt = ST_HICCUP;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r     <= ST_HICCUP;
      charge_r <= 1'b0;
      v_on_d_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      charge_r <= charge_nxt;
      v_on_d_r <= v_on;
    end
  end

  // Decoded requests feeding the output flops
  wire       skip_req;
  wire       drive_req;
  wire       source_req;
  wire [7:0] fold_diff;
  wire [7:0] fold_freq;

  assign skip_req   = (feedback_level < `OHS_FB_SKIP);
  assign drive_req  = (st_nxt == ST_START || st_nxt == ST_RUN) && !skip_req;
  assign source_req = charge_nxt && (st_nxt == ST_HICCUP || st_nxt == ST_LATCH);

  // Fold slope near 1.95 kHz per code: doubled step minus one per 16 codes
  assign fold_diff  = feedback_level - `OHS_FB_FMIN;
  assign fold_freq  = `OHS_FREQ_MIN_KHZ + {fold_diff[6:0], 1'b0}
                      - {4'h0, fold_diff[7:4]};

  // Outputs registered; drive off at once in any off state
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      skip_cycle <= 1'b0;
    else
      skip_cycle <= skip_req;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      gate_drive_enable <= 1'b0;
    else
      gate_drive_enable <= drive_req;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      startup_source_input <= 1'b0;
    else
      startup_source_input <= source_req;
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      soft_start <= 1'b0;
    else
      soft_start <= (st_nxt == ST_START);
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      latched_off <= 1'b0;
    else
      latched_off <= (st_nxt == ST_LATCH);
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      switch_freq_khz <= `OHS_FREQ_NOM_KHZ;
    else if (feedback_level >= `OHS_FB_FOLD)
      switch_freq_khz <= `OHS_FREQ_NOM_KHZ;
    else if (feedback_level <= `OHS_FB_FMIN)
      switch_freq_khz <= `OHS_FREQ_MIN_KHZ;
    else
      switch_freq_khz <= fold_freq;
  end

  // Setpoint in 20 mV feedback codes, clamped at the top, frozen at 8'h0D at or below the low end
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      peak_setpoint <= `OHS_FB_PEAK_HI;
    else if (feedback_level >= `OHS_FB_PEAK_HI)
      peak_setpoint <= `OHS_FB_PEAK_HI;
    else if (feedback_level <= `OHS_FB_PEAK_LO)
      peak_setpoint <= `OHS_PEAK_FROZEN;
    else
      peak_setpoint <= feedback_level;
  end
endmodule // ohs_sequencer

// File: test/ohs_seq_properties.sv
// Checker for the hiccup sequencer outputs.
// Assumes binding to every sequencer instance.
`timescale 1ns/10ps
module ohs_seq_properties (
  input wire       clock,
  input wire       resetn,
  input wire       error_flag,
  input wire       vcc_above_on,
  input wire       vcc_below_min,
  input wire       vcc_below_reset,
  input wire       line_loss_detect,
  input wire [7:0] feedback_level,
  input wire       gate_drive_enable,
  input wire       startup_source_input,
  input wire       soft_start,
  input wire       latched_off,
  input wire       skip_cycle,
  input wire [7:0] switch_freq_khz,
  input wire [7:0] peak_setpoint
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_skip; $past(resetn) |-> skip_cycle == ($past(feedback_level) < 8'h28); endproperty
  a_skip: assert property (p_skip) else $error("skip mismatch");
  property p_floor; $past(resetn) && $past(feedback_level) <= 8'h4B |-> switch_freq_khz == 8'h1A;
  endproperty
  a_floor: assert property (p_floor) else $error("floor freq");
  property p_nom; $past(resetn) && $past(feedback_level) >= 8'h5F |-> switch_freq_khz == 8'h41;
  endproperty
  a_nom: assert property (p_nom) else $error("nominal freq");
  property p_frozen; $past(resetn) && $past(feedback_level) <= 8'h32 |-> peak_setpoint == 8'h0D;
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen peak");
  property p_track; $past(resetn) && $past(feedback_level) > 8'h32 |->
    peak_setpoint == (($past(feedback_level) > 8'hA0) ? 8'hA0 : $past(feedback_level)); endproperty
  a_track: assert property (p_track) else $error("peak track");
  property p_skip_drv; skip_cycle && $past(skip_cycle) |-> !gate_drive_enable; endproperty
  a_skip_drv: assert property (p_skip_drv) else $error("drive in skip");
  property p_latch; latched_off && $past(latched_off) |-> !gate_drive_enable; endproperty
  a_latch: assert property (p_latch) else $error("drive while latched");
  property p_soft; $rose(gate_drive_enable) && !$past(skip_cycle) && !$past(skip_cycle, 2)
    |-> soft_start; endproperty
  a_soft: assert property (p_soft) else $error("restart without soft-start");
  c_restart: cover property ($rose(soft_start));
  c_stop: cover property ($fell(gate_drive_enable));
  c_skip: cover property ($rose(skip_cycle));
endmodule // ohs_seq_properties
bind ohs_sequencer ohs_seq_properties u_ohs_seq_properties (.clock(clock), .resetn(resetn),
  .error_flag(error_flag), .vcc_above_on(vcc_above_on), .vcc_below_min(vcc_below_min),
  .vcc_below_reset(vcc_below_reset), .line_loss_detect(line_loss_detect),
  .feedback_level(feedback_level), .gate_drive_enable(gate_drive_enable),
  .startup_source_input(startup_source_input), .soft_start(soft_start),
  .latched_off(latched_off), .skip_cycle(skip_cycle), .switch_freq_khz(switch_freq_khz),
  .peak_setpoint(peak_setpoint));

// File: test/ohs_supply_model.sv
// Supply model: charges on source, holds while driving.
// Assumes one clock; thresholds arbitrary.
`timescale 1ns/10ps
module ohs_supply_model (
  input  wire clock,
  input  wire src_on,
  input  wire drv_on,
  output wire above_on,
  output wire below_min
);
  integer lvl = 0;
  always @(posedge clock) begin
    if (src_on) lvl <= lvl + 2;
    else if (!drv_on && lvl > 0) lvl <= lvl - 1; // Aux winding dead without drive
  end
  assign above_on  = (lvl >= 40);
  assign below_min = (lvl < 20);
endmodule // ohs_supply_model

// File: test/overload_hiccup_sequencer_tb_top.sv
// Bench: start-up, fault hiccup, line recovery, feedback map.
// Assumes short timer parameters.
`timescale 1ns/10ps
module overload_hiccup_sequencer_tb_top;
  reg        clock = 0;
  reg        resetn = 0;
  reg        ef = 0;
  reg        ll = 0;
  reg  [7:0] fb = 8'hC8;
  wire       drv, src, ss, lat, skp, ab, bl;
  wire       drv2, src2, lat2, ab2, bl2;
  wire [7:0] fq, pk;
  integer    err_count = 0;
  integer    n_compared = 0;
  integer    n, i;
  always #2.5 clock = ~clock;
  ohs_sequencer #(.TICK_CYC(2), .FAULT_TICKS(10), .RECOV_TICKS(30)) u_ohs_sequencer (
    .clock(clock), .resetn(resetn), .error_flag(ef), .vcc_above_on(ab), .vcc_below_min(bl),
    .vcc_below_reset(1'b0), .line_loss_detect(ll), .feedback_level(fb),
    .gate_drive_enable(drv), .startup_source_input(src), .soft_start(ss),
    .latched_off(lat), .skip_cycle(skp), .switch_freq_khz(fq), .peak_setpoint(pk));
  ohs_supply_model u_ohs_supply_model (.clock(clock), .src_on(src), .drv_on(drv),
    .above_on(ab), .below_min(bl));
  // Latch-option copy shares the stimulus, own supply
  ohs_sequencer #(.TICK_CYC(2), .FAULT_TICKS(10), .RECOV_TICKS(30), .LATCH_OPT(1'b1))
    u_ohs_sequencer_latch (
    .clock(clock), .resetn(resetn), .error_flag(ef), .vcc_above_on(ab2), .vcc_below_min(bl2),
    .vcc_below_reset(1'b0), .line_loss_detect(ll), .feedback_level(fb),
    .gate_drive_enable(drv2), .startup_source_input(src2), .soft_start(),
    .latched_off(lat2), .skip_cycle(), .switch_freq_khz(), .peak_setpoint());
  ohs_supply_model u_ohs_supply_model_latch (.clock(clock), .src_on(src2), .drv_on(drv2),
    .above_on(ab2), .below_min(bl2));
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input ok, input [127:0] m);
    begin
      n_compared = n_compared + 1;
      if (!ok) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t %0s", $time, m);
      end
    end
  endtask
  task wait_drv(input v);
    begin
      n = 0;
      while (drv !== v && n < 400) begin
        @(negedge clock);
        n = n + 1;
      end
      if (n == 400) begin
        chk(1'b0, "timeout");
        results;
      end
    end
  endtask
  initial begin
    repeat (20) @(negedge clock);
    resetn = 1;
    wait_drv(1'b1);
    chk(ss === 1'b1, "start soft");
    repeat (8) @(negedge clock);
    ef = 1;
    repeat (12) @(negedge clock);
    ef = 0;
    repeat (10) @(negedge clock);
    chk(drv === 1'b1, "short err");
    ef = 1;
    wait_drv(1'b0);
    chk(n >= 20 && n <= 30, "fault time");
    chk(lat2 === 1'b1 && drv2 === 1'b0, "latch opt");
    ef = 0;
    wait_drv(1'b1);
    chk(n >= 60 && ss === 1'b1, "recovery");
    chk(lat === 1'b0 && src === 1'b0, "auto no latch");
    chk(lat2 === 1'b1 && drv2 === 1'b0, "stay latched");
    repeat (8) @(negedge clock);
    ef = 1;
    wait_drv(1'b0);
    ef = 0;
    ll = 1;
    repeat (5) @(negedge clock);
    ll = 0;
    wait_drv(1'b1);
    chk(n < 60, "line recovery");
    chk(lat2 === 1'b0, "latch cleared");
    for (i = 0; i < 6; i = i + 1) begin
      fb = 8'h10 + i * 8'h24;
      repeat (2) @(negedge clock);
      chk(skp === (fb < 8'h28), "skip");
      chk(pk === (fb <= 8'h32 ? 8'h0D : (fb > 8'hA0 ? 8'hA0 : fb)), "peak");
      if (fb <= 8'h4B || fb >= 8'h5F) chk(fq === (fb <= 8'h4B ? 8'h1A : 8'h41), "freq");
      else chk(fq > 8'h1A && fq < 8'h41, "fold freq");
    end
    results;
  end
endmodule // overload_hiccup_sequencer_tb_top
